// ===== logic/rpo_row_program.sv
/*
  Row programming engine for code memory, data EEPROM read-back and
  seven configuration words with oscillator word decode.
  Assumes an Avalon-MM master with waitrequest on clk_sys; rstn is
  asynchronous and released here through two flip-flops.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - rows cross panel edges with no fuss
// - seven 16-bit settable config words
// - oscillator power-on setup; code protect blocks access
// - clock switch field: 1x off, 01, 00
// - power-on source field four selections
// - external clock with PLLs, pin I/O
// - 1011 external clock, pin outputs Fosc/4
// - code 1010 reserved, not used
// - 1001/1000 external RC, out or I/O
// - mid crystal with PLL 16/8/4 or none
// - 001x fast crystal, 000x slow crystal
// - a row is thirty-two 24-bit words
// - bulk erase sets code, eeprom and config bits to one
module rpo_row_program
  import rpo_pkg::*;
#(
  parameter int ERASE_WORDS = CODE_WORDS
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             clkSwitchEn,
  output logic             clkMonitorEn,
  output rpo_src_t         porOscSource,
  output rpo_mode_t        primaryOscMode,
  output rpo_pll_t         pllMult,
  output logic             secondOscPinClkOut,
  output logic             oscModeReserved,
  output logic             codeProtect,
  output logic             busy
);

  typedef struct packed {
    logic                              ack;
    logic [31:0]                       rdData;
    rpo_eng_t                          eng;
    logic [23:0]                       rowDestAddr;
    logic [5:0]                        bufCnt;
    logic [4:0]                        progIdx;
    logic [15:0]                       eraseIdx;
    logic                              err;
    logic [15:0]                       rowCount;
    logic [23:0]                       codeRdAddr;
    logic [8:0]                        eeAddr;
    logic [CFG_COUNT-1:0][CFG_W-1:0]   cfg;
    logic                              swEn;
    logic                              monEn;
    rpo_src_t                          src;
    rpo_mode_t                         mode;
    rpo_pll_t                          pll;
    logic                              pinOut;
    logic                              rsvd;
  } rpo_state_t;

  rpo_state_t  st;
  rpo_state_t  next_st;
  logic        rstSync1;
  logic        rstnSync;

  logic [WORD_W-1:0] codeMem [CODE_WORDS];
  logic [WORD_W-1:0] rowBuf  [ROW_WORDS];
  logic [EE_W-1:0]   eeMem   [EE_WORDS];

  logic              codeWe;
  logic [15:0]       codeWAddr;
  logic [WORD_W-1:0] codeWData;
  logic              bufWe;
  logic              eeWe;
  logic [8:0]        eeWAddr;
  logic [EE_W-1:0]   eeWData;
  logic              wrEn;
  logic              protect;

  // program address counts two per instruction word
  function automatic logic [15:0] wordIdx(input logic [23:0] addr);
    return addr[16:1];
  endfunction

  // byte lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // reset release through two flops; async assert only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstSync1 <= 1'b0;
      rstnSync <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstnSync <= rstSync1;
    end
  end

  assign wrEn        = write & st.ack;
  assign waitrequest = (read | write) & ~st.ack; // one wait cycle per access
  assign protect     = ~st.cfg[CFG_PROT_IDX][PROT_BIT]; // erased state unprotected

  // next state, register decode and engine stepping
  always_comb begin
    logic [3:0] primary_osc_mode_sel;
    logic [7:0] cfgOff;
    logic [31:0] mrg;
    primary_osc_mode_sel       = '0;
    cfgOff    = '0;
    mrg       = '0;
    next_st   = st;
    codeWe    = 1'b0;
    codeWAddr = '0;
    codeWData = '0;
    bufWe     = 1'b0;
    eeWe      = 1'b0;
    eeWAddr   = '0;
    eeWData   = '0;
    next_st.ack = (read | write) & ~st.ack;

    // read data prepared in the wait cycle, presented when ack lowers waitrequest
    if (read & ~st.ack) begin
      next_st.rdData = '0;
      case (address & 8'hFC)
        OFF_STATUS: begin
          next_st.rdData[ST_BUSY]     = (st.eng != RPO_IDLE);
          next_st.rdData[ST_ERR]      = st.err;
          next_st.rdData[ST_PROTECT]  = protect;
          next_st.rdData[ST_BUF_FULL] = (st.bufCnt == 6'(ROW_WORDS));
        end
        OFF_ROW_ADDR:  next_st.rdData[23:0] = st.rowDestAddr;
        OFF_CODE_ADDR: next_st.rdData[23:0] = st.codeRdAddr;
        OFF_CODE_DATA: begin
          if (!protect && st.codeRdAddr < CODE_END) begin
            next_st.rdData[WORD_W-1:0] = codeMem[wordIdx(st.codeRdAddr)];
          end
        end
        OFF_EE_ADDR:   next_st.rdData[8:0] = st.eeAddr;
        OFF_EE_DATA:   next_st.rdData[EE_W-1:0] = eeMem[st.eeAddr];
        OFF_ROW_COUNT: next_st.rdData[15:0] = st.rowCount;
        OFF_OSC_STAT: begin
          next_st.rdData[OS_SW_EN]          = st.swEn;
          next_st.rdData[OS_MON_EN]         = st.monEn;
          next_st.rdData[OS_SRC_LO +: 2]    = st.src;
          next_st.rdData[OS_MODE_LO +: 4]   = st.mode;
          next_st.rdData[OS_PLL_LO +: 2]    = st.pll;
          next_st.rdData[OS_PIN_OUT]        = st.pinOut;
          next_st.rdData[OS_RSVD]           = st.rsvd;
        end
        default: begin
          for (int i = 0; i < CFG_COUNT; i++) begin
            cfgOff = OFF_CFG_BASE + 8'(i * 4);
            if ((address & 8'hFC) == cfgOff) begin
              next_st.rdData[CFG_W-1:0] = st.cfg[i];
            end
          end
        end
      endcase
    end

    // writes take effect on the edge where waitrequest is low
    if (wrEn) begin
      case (address & 8'hFC)
        OFF_CTRL: begin
          if (writedata[CTRL_ERR_CLR]) begin
            next_st.err = 1'b0;
          end
          if (st.eng != RPO_IDLE && (writedata[CTRL_ROW_PROG] | writedata[CTRL_ERASE])) begin
            next_st.err = 1'b1; // busy: command refused
          end else if (writedata[CTRL_ERASE]) begin
            next_st.eng      = RPO_ERASE;
            next_st.eraseIdx = '0;
          end else if (writedata[CTRL_ROW_PROG]) begin
            // a command needs a full row, an aligned row address in range and no protect
            if (st.bufCnt != 6'(ROW_WORDS) || (st.rowDestAddr[5:0] & ROW_MASK) != '0
                || st.rowDestAddr >= CODE_END || protect) begin
              next_st.err = 1'b1;
            end else begin
              next_st.eng     = RPO_ROW_PROG;
              next_st.progIdx = '0;
            end
          end
        end
        OFF_ROW_ADDR: begin
          if (st.eng == RPO_IDLE) begin
            next_st.rowDestAddr = writedata[23:0];
            next_st.bufCnt      = '0;
          end else begin
            next_st.err = 1'b1;
          end
        end
        OFF_ROW_DATA: begin
          if (st.eng == RPO_IDLE && st.bufCnt != 6'(ROW_WORDS)) begin
            bufWe          = 1'b1;
            next_st.bufCnt = st.bufCnt + 6'd1;
          end else begin
            next_st.err = 1'b1; // overfull row or engine busy
          end
        end
        OFF_CODE_ADDR: next_st.codeRdAddr = writedata[23:0];
        OFF_EE_ADDR:   next_st.eeAddr = writedata[8:0];
        OFF_EE_DATA: begin
          if (st.eng == RPO_IDLE) begin
            eeWe    = 1'b1;
            eeWAddr = st.eeAddr;
            eeWData = writedata[EE_W-1:0];
          end else begin
            next_st.err = 1'b1;
          end
        end
        OFF_ROW_COUNT: next_st.rowCount = writedata[15:0];
        default: begin
          for (int i = 0; i < CFG_COUNT; i++) begin
            cfgOff = OFF_CFG_BASE + 8'(i * 4);
            if ((address & 8'hFC) == cfgOff && st.eng == RPO_IDLE) begin
              // every bit may be set or cleared
              mrg            = merge({16'h0000, st.cfg[i]}, writedata, byteenable);
              next_st.cfg[i] = mrg[CFG_W-1:0];
            end
          end
        end
      endcase
    end

    // engine: one word per cycle
    case (st.eng)
      RPO_ROW_PROG: begin
        codeWe          = 1'b1;
        codeWAddr       = wordIdx(st.rowDestAddr) + 16'(st.progIdx);
        codeWData       = rowBuf[st.progIdx];
        next_st.progIdx = st.progIdx + 5'd1;
        if (st.progIdx == 5'(ROW_WORDS - 1)) begin
          next_st.eng      = RPO_IDLE;
          next_st.bufCnt   = '0;
          next_st.rowCount = st.rowCount + 16'd1;
        end
      end
      RPO_ERASE: begin
        codeWe    = 1'b1;
        codeWAddr = st.eraseIdx;
        codeWData = '1;
        if (st.eraseIdx < 16'(EE_WORDS)) begin
          eeWe    = 1'b1;
          eeWAddr = st.eraseIdx[8:0];
          eeWData = '1;
        end
        next_st.eraseIdx = st.eraseIdx + 16'd1;
        if (st.eraseIdx == 16'(ERASE_WORDS - 1)) begin
          next_st.eng      = RPO_IDLE;
          next_st.rowCount = '0;
          next_st.bufCnt   = '0;
          for (int i = 0; i < CFG_COUNT; i++) begin
            next_st.cfg[i] = CFG_ERASED; // software must rewrite afterwards
          end
        end
      end
      default: ;
    endcase

    // oscillator word decode, registered so outputs come from flops
    next_st.swEn  = ~st.cfg[CFG_OSC_IDX][CKSM_HI];
    next_st.monEn = ~st.cfg[CFG_OSC_IDX][CKSM_HI] & ~st.cfg[CFG_OSC_IDX][CKSM_LO];
    next_st.src   = rpo_src_t'(st.cfg[CFG_OSC_IDX][FOS_HI:FOS_LO]);
    primary_osc_mode_sel            = st.cfg[CFG_OSC_IDX][FPR_HI:FPR_LO];
    next_st.pll    = RPO_PLL_NONE;
    next_st.pinOut = 1'b0;
    next_st.rsvd   = 1'b0;
    case (primary_osc_mode_sel)
      4'b1111, 4'b1110, 4'b1101, 4'b1100: begin
        next_st.mode = RPO_EXT_CLOCK_IO;
        next_st.pll  = rpo_pll_t'(primary_osc_mode_sel[1:0]);
      end
      4'b1011: begin
        next_st.mode   = RPO_EXT_CLOCK_OUT;
        next_st.pinOut = 1'b1;
      end
      4'b1010: begin
        next_st.mode = RPO_RESERVED;
        next_st.rsvd = 1'b1;
      end
      4'b1001: begin
        next_st.mode   = RPO_EXT_RC_OUT;
        next_st.pinOut = 1'b1;
      end
      4'b1000: next_st.mode = RPO_EXT_RC_IO;
      4'b0111, 4'b0110, 4'b0101, 4'b0100: begin
        next_st.mode = RPO_MID_CRYSTAL;
        next_st.pll  = rpo_pll_t'(primary_osc_mode_sel[1:0]);
      end
      4'b0011, 4'b0010: next_st.mode = RPO_FAST_CRYSTAL;
      default: next_st.mode = RPO_SLOW_CRYSTAL;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rstnSync) begin
    if (!rstnSync) begin
      st          <= '0;
      st.eng      <= RPO_IDLE;
      st.cfg      <= {CFG_COUNT{CFG_ERASED}};
      st.swEn     <= 1'b0;
      st.monEn    <= 1'b0;
      st.src      <= RPO_SRC_PRIMARY;
      st.mode     <= RPO_EXT_CLOCK_IO;
      st.pll      <= RPO_PLL_16X;
    end else begin
      st <= next_st;
    end
  end

  // memory arrays carry no reset; bulk erase sets code and eeprom, not the row buffer
  always_ff @(posedge clk_sys) begin
    if (codeWe) begin
      codeMem[codeWAddr] <= codeWData;
    end
    if (bufWe) begin
      rowBuf[st.bufCnt[4:0]] <= writedata[WORD_W-1:0];
    end
    if (eeWe) begin
      eeMem[eeWAddr] <= eeWData;
    end
  end

  assign readdata           = st.rdData;
  assign clkSwitchEn        = st.swEn;
  assign clkMonitorEn       = st.monEn;
  assign porOscSource       = st.src;
  assign primaryOscMode     = st.mode;
  assign pllMult            = st.pll;
  assign secondOscPinClkOut = st.pinOut;
  assign oscModeReserved    = st.rsvd;
  assign codeProtect        = protect;
  assign busy               = (st.eng != RPO_IDLE);

endmodule // rpo_row_program
`default_nettype wire

// ===== logic/rpo_pkg.sv
/*
  Constants and types shared by the row programming and oscillator
  configuration block: register map, field positions, sizes, encodings.
  Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
`default_nettype none
package rpo_pkg;
  // register byte addresses
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_ROW_ADDR  = 8'h08;
  localparam logic [7:0] OFF_ROW_DATA  = 8'h0C;
  localparam logic [7:0] OFF_CODE_ADDR = 8'h10;
  localparam logic [7:0] OFF_CODE_DATA = 8'h14;
  localparam logic [7:0] OFF_EE_ADDR   = 8'h18;
  localparam logic [7:0] OFF_EE_DATA   = 8'h1C;
  localparam logic [7:0] OFF_ROW_COUNT = 8'h20;
  localparam logic [7:0] OFF_OSC_STAT  = 8'h24;
  localparam logic [7:0] OFF_CFG_BASE  = 8'h40;
  // control bits
  localparam int CTRL_ROW_PROG = 0;
  localparam int CTRL_ERASE    = 1;
  localparam int CTRL_ERR_CLR  = 2;
  // status bits
  localparam int ST_BUSY     = 0;
  localparam int ST_ERR      = 1;
  localparam int ST_PROTECT  = 2;
  localparam int ST_BUF_FULL = 3;
  // memory geometry
  localparam int WORD_W    = 24;
  localparam int ROW_WORDS = 32;
  localparam int NUM_ROWS  = 1536;
  localparam int CODE_WORDS = ROW_WORDS * NUM_ROWS;
  localparam logic [23:0] ROW_STEP  = 24'h00_0040;
  localparam logic [23:0] CODE_END  = 24'h01_8000;
  localparam logic [5:0]  ROW_MASK  = 6'h3F;
  localparam int EE_WORDS = 512;
  localparam int EE_W     = 16;
  // configuration words
  localparam int CFG_COUNT = 7;
  localparam int CFG_W     = 16;
  localparam logic [15:0] CFG_ERASED = 16'hFFFF;
  localparam int CFG_OSC_IDX  = 0;
  localparam int CFG_PROT_IDX = 6;
  localparam int PROT_BIT     = 0;
  localparam int CKSM_HI = 15;
  localparam int CKSM_LO = 14;
  localparam int FOS_HI  = 9;
  localparam int FOS_LO  = 8;
  localparam int FPR_HI  = 3;
  localparam int FPR_LO  = 0;
  // oscillator status register fields
  localparam int OS_SW_EN   = 0;
  localparam int OS_MON_EN  = 1;
  localparam int OS_SRC_LO  = 2;
  localparam int OS_MODE_LO = 4;
  localparam int OS_PLL_LO  = 8;
  localparam int OS_PIN_OUT = 10;
  localparam int OS_RSVD    = 11;

  typedef enum logic [1:0] {
    RPO_SRC_LP32K, RPO_SRC_FAST_RC, RPO_SRC_LP_RC, RPO_SRC_PRIMARY
  } rpo_src_t;

  typedef enum logic [3:0] {
    RPO_EXT_CLOCK_IO, RPO_EXT_CLOCK_OUT, RPO_RESERVED, RPO_EXT_RC_OUT,
    RPO_EXT_RC_IO, RPO_MID_CRYSTAL, RPO_FAST_CRYSTAL, RPO_SLOW_CRYSTAL
  } rpo_mode_t;

  typedef enum logic [1:0] {RPO_PLL_NONE, RPO_PLL_4X, RPO_PLL_8X, RPO_PLL_16X} rpo_pll_t;

  typedef enum logic [1:0] {RPO_IDLE, RPO_ROW_PROG, RPO_ERASE} rpo_eng_t;
endpackage
`default_nettype wire

// ===== verification/rpo_row_program_chk.sv
/*
  Port checker for rpo_row_program: bus answer timing, oscillator
  decode relations and busy run lengths.
  Assumes one clock clk_sys and async active-low rstn.
*/
`timescale 1ns/1ns
`default_nettype none
module rpo_row_program_chk
  import rpo_pkg::*;
#(
  parameter int ERASE_WORDS = CODE_WORDS
) (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        clkSwitchEn,
  input wire logic        clkMonitorEn,
  input wire rpo_src_t    porOscSource,
  input wire rpo_mode_t   primaryOscMode,
  input wire rpo_pll_t    pllMult,
  input wire logic        secondOscPinClkOut,
  input wire logic        oscModeReserved,
  input wire logic        codeProtect,
  input wire logic        busy
);
  int bCnt;
  // length of the running busy period; erase and row differ
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) bCnt <= 0;
    else if (busy) bCnt <= bCnt + 1;
    else bCnt <= 0;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_req; $rose(read || write); endsequence
  // config word write taken while idle, all lanes
  sequence s_cfg;
    write && !waitrequest && address == OFF_CFG_BASE && byteenable == 4'hF && !busy;
  endsequence
  property p_ans; s_req |-> waitrequest ##1 !waitrequest; endproperty
  property p_sw; s_cfg |-> ##2 clkSwitchEn == !$past(writedata[15], 2); endproperty
  property p_src; s_cfg |-> ##2 porOscSource == $past(writedata[9:8], 2); endproperty
  property p_mon; clkMonitorEn |-> clkSwitchEn; endproperty
  property p_rsv; oscModeReserved == (primaryOscMode == RPO_RESERVED); endproperty
  property p_pin;
    secondOscPinClkOut |-> primaryOscMode inside {RPO_EXT_CLOCK_OUT, RPO_EXT_RC_OUT};
  endproperty
  property p_pll;
    pllMult != RPO_PLL_NONE |-> primaryOscMode inside {RPO_EXT_CLOCK_IO, RPO_MID_CRYSTAL};
  endproperty
  property p_stat;
    read && !waitrequest && address == OFF_OSC_STAT |-> readdata[11:0] == {oscModeReserved,
      secondOscPinClkOut, pllMult, primaryOscMode, porOscSource, clkMonitorEn, clkSwitchEn};
  endproperty
  property p_bsy; $fell(busy) |-> bCnt == 32 || bCnt == ERASE_WORDS; endproperty
  a_ans: assert property (p_ans) else $error("bus answer not one cycle");
  a_sw: assert property (p_sw) else $error("switch enable wrong");
  a_src: assert property (p_src) else $error("source wrong");
  a_mon: assert property (p_mon) else $error("monitor without switch");
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
  a_pin: assert property (p_pin) else $error("pin output wrong");
  a_pll: assert property (p_pll) else $error("pll in wrong mode");
  a_stat: assert property (p_stat) else $error("status word mismatch");
  a_bsy: assert property (p_bsy) else $error("busy length wrong");
endmodule // rpo_row_program_chk
bind rpo_row_program rpo_row_program_chk #(.ERASE_WORDS(ERASE_WORDS)) chk_i (.*);
`default_nettype wire

// ===== verification/rpo_prog_model.sv
/*
  External programmer model: Avalon master that sends row commands.
  Assumes the slave answers with waitrequest on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module rpo_prog_model
  import rpo_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output var logic [7:0]   address,
  output var logic         read,
  output var logic         write,
  output var logic [3:0]   byteenable,
  output var logic [31:0]  writedata
);
  int hangs;
  // bus idle from time zero
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hF;
    writedata = 32'h0000_0000;
    hangs = 0;
  end
  // one transfer; held until waitrequest seen low, bounded wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    n = 0;
    // sample mid-cycle: settled there, and equal to what the next edge sees
    @(negedge clk_sys);
    while (waitrequest !== 1'b0 && n < 64) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 64) hangs++;
    q = readdata; // read data stands in the answer cycle
    @(posedge clk_sys); // accepting edge; release only after it
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  // eeprom is read over the bus only, never by table reads
  // poll status until the engine is idle again
  task automatic idle();
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      xfer(1'b0, OFF_STATUS, 32'h0000_0000, s);
      n++;
    end while (s[ST_BUSY] !== 1'b0 && n < 1000);
    if (n >= 1000) hangs++;
  endtask
  // one command per row, full rows, address stepped per row
  task automatic rows(input int cnt, input logic [23:0] base);
    logic [23:0] dst;
    int left;
    dst = base;
    left = cnt; // start count
    while (left > 0) begin
      wr(OFF_ROW_ADDR, {8'h00, dst}); // row target
      for (int i = 0; i < ROW_WORDS; i++) begin
        wr(OFF_ROW_DATA, {8'h00, dst[15:0], 8'(i)}); // whole row
      end
      wr(OFF_CTRL, 32'h0000_0001);
      idle();
      left = left - 1; // count down
      if (left > 0) dst = dst + ROW_STEP; // next row
    end
  endtask
endmodule // rpo_prog_model
`default_nettype wire

// ===== verification/tb.sv
/*
  Self-checking bench for rpo_row_program with the programmer model.
  Assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rpo_pkg::*;
  typedef struct {logic [15:0] w; logic [11:0] e;} rpo_row_t;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] address;
  logic read, write, waitrequest, clkSwitchEn, clkMonitorEn;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata;
  rpo_src_t porOscSource;
  rpo_mode_t primaryOscMode;
  rpo_pll_t pllMult;
  logic secondOscPinClkOut, oscModeReserved, codeProtect, busy;
  int badCount = 0;
  int nTests = 0;
  // oscillator word and the status bits it should give
  rpo_row_t rows[16] = '{
    '{16'h0000, 12'h073}, '{16'h4001, 12'h071}, '{16'h8002, 12'h060}, '{16'hC003, 12'h060},
    '{16'h0104, 12'h057}, '{16'h4105, 12'h155}, '{16'h8106, 12'h254}, '{16'hC107, 12'h354},
    '{16'h0208, 12'h04B}, '{16'h4209, 12'h439}, '{16'h820A, 12'h828}, '{16'hC20B, 12'h418},
    '{16'h030C, 12'h00F}, '{16'h430D, 12'h10D}, '{16'h830E, 12'h20C}, '{16'hC30F, 12'h30C}};
  rpo_row_program #(.ERASE_WORDS(600)) rpo_row_program_i (.*);
  rpo_prog_model rpo_prog_model_i (.*);
  // 125 MHz
  always #4 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rpo_prog_model_i.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    rpo_prog_model_i.wr(a, d);
  endtask
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, well beyond the expected run of about 1100 cycles
  initial begin
    #160_000;
    badCount++;
    endOfTest();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc(OFF_OSC_STAT, 32'h0000_030C); // erased decode
    rdc(OFF_CFG_BASE + 8'h18, 32'h0000_FFFF); // last word
    rdc(8'h30, 32'h0000_0000); // unmapped reads zero
    foreach (rows[k]) begin
      wr(OFF_CFG_BASE, {16'h0000, rows[k].w});
      rdc(OFF_CFG_BASE, {16'h0000, rows[k].w}); // word kept
      rdc(OFF_OSC_STAT, {20'h0_0000, rows[k].e}); // decode
      chk({20'h0_0000, oscModeReserved, secondOscPinClkOut, pllMult, primaryOscMode,
           porOscSource, clkMonitorEn, clkSwitchEn}, {20'h0_0000, rows[k].e});
    end
    // bulk erase, then config and eeprom read erased, row count zero
    wr(OFF_CTRL, 32'h0000_0002); // erase first, restart point
    rpo_prog_model_i.idle();
    rdc(OFF_CFG_BASE, 32'h0000_FFFF); // cfg erased
    rdc(OFF_ROW_COUNT, 32'h0000_0000);
    wr(OFF_CFG_BASE, 32'h0000_FFFF); // rewrite after erase
    wr(OFF_EE_ADDR, 32'h0000_01FF);
    rdc(OFF_EE_DATA, 32'h0000_FFFF); // eeprom erased
    wr(OFF_EE_ADDR, 32'h0000_0005);
    wr(OFF_EE_DATA, 32'h0000_1234);
    rdc(OFF_EE_DATA, 32'h0000_1234); // readback, not checksum
    // two rows crossing the panel edge at word 0x4000
    rpo_prog_model_i.rows(2, 24'h00_7FC0);
    rdc(OFF_ROW_COUNT, 32'h0000_0002); // two commands
    wr(OFF_CODE_ADDR, 32'h0000_7FFE);
    rdc(OFF_CODE_DATA, 32'h007F_C01F); // last word
    wr(OFF_CODE_ADDR, 32'h0000_8002);
    rdc(OFF_CODE_DATA, 32'h0080_0001); // next panel
    // misaligned row refused, then error cleared
    wr(OFF_ROW_ADDR, 32'h0000_0021);
    wr(OFF_CTRL, 32'h0000_0001);
    rdc(OFF_STATUS, 32'h0000_0002);
    wr(OFF_CTRL, 32'h0000_0004);
    rdc(OFF_STATUS, 32'h0000_0000);
    // protect bit blocks code reads
    wr(OFF_CFG_BASE + 8'h18, 32'h0000_FFFE);
    rdc(OFF_STATUS, 32'h0000_0004); // protect flag
    chk({31'h0000_0000, codeProtect}, 32'h0000_0001); // port
    rdc(OFF_CODE_DATA, 32'h0000_0000); // read blocked
    // reset in mid-run brings back erased words and an idle engine
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc(OFF_CFG_BASE + 8'h18, 32'h0000_FFFF); // reset value
    rdc(OFF_STATUS, 32'h0000_0000); // unprotected and idle
    chk({31'h0000_0000, busy}, 32'h0000_0000);
    chk(32'(rpo_prog_model_i.hangs), 32'h0000_0000);
    endOfTest();
  end
endmodule // tb
`default_nettype wire
